// *** core/tcirq_map.vh ***
// register map, field positions and codes of the timer counter core
`ifndef TCIRQ_MAP_VH
`define TCIRQ_MAP_VH
`define TCIRQ_ADDR_W 5
`define TCIRQ_OFS_STATUS_CONTROL 5'h00
`define TCIRQ_OFS_COUNTER_HIGH 5'h04
`define TCIRQ_OFS_COUNTER_LOW 5'h08
`define TCIRQ_OFS_MODULO_HIGH 5'h0c
`define TCIRQ_OFS_MODULO_LOW 5'h10
`define TCIRQ_OFS_CHAN0 5'h14
`define TCIRQ_OFS_CHAN1 5'h18
`define TCIRQ_BIT_FLAG 7
`define TCIRQ_BIT_IRQ_EN 6
`define TCIRQ_BIT_CENTER 5
`define TCIRQ_CS_HI 4
`define TCIRQ_CS_LO 3
`define TCIRQ_PS_HI 2
`define TCIRQ_PS_LO 0
`define TCIRQ_CS_NONE 2'h0
`define TCIRQ_CS_BUS 2'h1
`define TCIRQ_CS_FIXED 2'h2
`define TCIRQ_CS_EXT 2'h3
`define TCIRQ_CTRL_RESET 6'h00
`define TCIRQ_COUNT_RESET 16'h0000
`define TCIRQ_COUNT_MAX 16'hffff
`define TCIRQ_MODULO_RESET 16'h0000
`endif

// *** core/tcirq_prescaler.v ***
// power-of-two prescaler for the selected clock ticks
`timescale 1ns/1ps
module tcirq_prescaler #(
	parameter PS_W = 3,
	parameter DIV_W = 7
) (
	ref_clk,
	rst,
	tick_in,
	prescale_select,
	tick_out
);
	input wire ref_clk;
	input wire rst;
	input wire tick_in;
	input wire [PS_W-1:0] prescale_select;
	output wire tick_out;

	reg [DIV_W-1:0] div_r;
	wire [DIV_W-1:0] mask;

	// divide by 2**prescale_select: a tick passes when the masked low bits are all ones
	assign mask = ~({DIV_W{1'b1}} << prescale_select);
	assign tick_out = tick_in & ((div_r & mask) == mask);

	always @(posedge ref_clk) begin
		if (rst) begin
			div_r <= {DIV_W{1'b0}};
		end else if (tick_in) begin
			div_r <= div_r + {{(DIV_W-1){1'b0}}, 1'b1};
		end
	end
endmodule // tcirq_prescaler

// *** core/tcirq_core.v ***
// timer counter core with coherent counter reads, event flags and level interrupt
// How it works
// - two-bit clock source: 00 none, 01 bus, 10 fixed, 11 external.
// - prescale field divides selected clock by two to the field value.
// - counter visible as high and low byte registers; writes only clear it.
// - reading either byte latches both until the other byte is read.
// - reset or any status/control write returns the latch to idle.
// - reset zeroes the sixteen-bit counter.
// - any write to a counter byte zeroes counter and latch, data ignored.
// - overflow flag sets as counter steps past its terminal count.
// - channel flag sets on a rising edge of that channel's event pin.
// - interrupt request is active high.
// - enabled flag holds request as a level; disabled flag only polled.
// - flag clears only after a read seeing one, then a zero write.
// - a new event between read and write keeps the flag set.
// - without center mode overflow sets going from modulo to zero.
// - with no modulo limit overflow sets at ffff, rolling to zero outside center mode.
`timescale 1ns/1ps
`include "tcirq_map.vh"
module tcirq_core #(
	parameter NCH = 2,
	parameter CNT_W = 16
) (
	ref_clk,
	rst,
	avm_address,
	avm_read,
	avm_write,
	avm_writedata,
	avm_byteenable,
	avm_readdata,
	avm_waitrequest,
	fixed_clk_tick,
	ext_clk_pin,
	channel_event_pin,
	irq
);
	input wire ref_clk;
	input wire rst;
	input wire [`TCIRQ_ADDR_W-1:0] avm_address;
	input wire avm_read;
	input wire avm_write;
	input wire [31:0] avm_writedata;
	input wire [3:0] avm_byteenable;
	output reg [31:0] avm_readdata;
	output reg avm_waitrequest;
	input wire fixed_clk_tick;
	input wire ext_clk_pin;
	input wire [NCH-1:0] channel_event_pin;
	output reg irq;

	// three-stage pin synchroniser; a change counts once stages two and three agree
	reg [NCH:0] sync1_r;
	reg [NCH:0] sync2_r;
	reg [NCH:0] sync3_r;
	reg [NCH:0] pin_lvl_r;
	wire [NCH:0] pin_raw;
	wire [NCH:0] pin_lvl_nxt;
	wire [NCH:0] pin_rise;

	assign pin_raw = {channel_event_pin, ext_clk_pin};

	genvar gi;
	generate
		for (gi = 0; gi <= NCH; gi = gi + 1) begin : g_sync
			assign pin_lvl_nxt[gi] = (sync2_r[gi] == sync3_r[gi]) ? sync3_r[gi] : pin_lvl_r[gi];
			assign pin_rise[gi] = pin_lvl_nxt[gi] & ~pin_lvl_r[gi];
		end
	endgenerate

	always @(posedge ref_clk) begin
		if (rst) begin
			sync1_r <= {(NCH+1){1'b0}};
			sync2_r <= {(NCH+1){1'b0}};
			sync3_r <= {(NCH+1){1'b0}};
			pin_lvl_r <= {(NCH+1){1'b0}};
		end else begin
			sync1_r <= pin_raw;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			pin_lvl_r <= pin_lvl_nxt;
		end
	end

	// control state
	reg [1:0] clock_source_select_r;
	reg [2:0] prescale_select_r;
	reg center_align_select_r;
	reg overflow_irq_enable_r;
	reg overflow_flag_r;
	reg overflow_armed_r;
	reg [NCH-1:0] channel_irq_enable_r;
	reg [NCH-1:0] channel_event_flag_r;
	reg [NCH-1:0] channel_armed_r;
	reg [CNT_W-1:0] count_r;
	reg count_down_r;
	reg [CNT_W-1:0] modulo_r;
	reg [CNT_W-1:0] hold_r;
	reg latched_r;
	reg first_high_r;

	// bus decode: every access is taken in its first cycle and answered one cycle later
	wire take;
	wire do_rd;
	wire do_wr;
	wire wr_lane;
	wire [7:0] wbyte;
	assign take = (avm_read | avm_write) & avm_waitrequest;
	assign do_rd = take & avm_read;
	assign do_wr = take & avm_write;
	assign wr_lane = avm_byteenable[0];
	assign wbyte = avm_writedata[7:0];

	function hit;
		input [`TCIRQ_ADDR_W-1:0] a;
		input [`TCIRQ_ADDR_W-1:0] ofs;
		begin
			hit = (a == ofs);
		end
	endfunction

	function [`TCIRQ_ADDR_W-1:0] chan_ofs;
		input integer n;
		begin
			chan_ofs = `TCIRQ_OFS_CHAN0 + n[`TCIRQ_ADDR_W-1:0] * 5'h04;
		end
	endfunction

	wire sc_rd;
	wire sc_wr;
	wire cnt_rd_hi;
	wire cnt_rd_lo;
	wire cnt_wr;
	assign sc_rd = do_rd & hit(avm_address, `TCIRQ_OFS_STATUS_CONTROL);
	assign sc_wr = do_wr & wr_lane & hit(avm_address, `TCIRQ_OFS_STATUS_CONTROL);
	assign cnt_rd_hi = do_rd & hit(avm_address, `TCIRQ_OFS_COUNTER_HIGH);
	assign cnt_rd_lo = do_rd & hit(avm_address, `TCIRQ_OFS_COUNTER_LOW);
	assign cnt_wr = do_wr & wr_lane & (hit(avm_address, `TCIRQ_OFS_COUNTER_HIGH) |
		hit(avm_address, `TCIRQ_OFS_COUNTER_LOW));

	// clock source and prescaler
	reg src_tick;
	wire presc_tick;
	always @* begin
		case (clock_source_select_r)
			`TCIRQ_CS_NONE: src_tick = 1'b0;
			`TCIRQ_CS_BUS: src_tick = 1'b1;
			`TCIRQ_CS_FIXED: src_tick = fixed_clk_tick;
			`TCIRQ_CS_EXT: src_tick = pin_rise[0];
			default: src_tick = 1'b0;
		endcase
	end

	tcirq_prescaler #(
		.PS_W(3),
		.DIV_W(7)
	) u_presc (
		.ref_clk(ref_clk),
		.rst(rst),
		.tick_in(src_tick),
		.prescale_select(prescale_select_r),
		.tick_out(presc_tick)
	);

	// counting; a zero modulo means no limit, so the terminal count is all ones
	wire [CNT_W-1:0] terminal;
	wire at_terminal;
	reg [CNT_W-1:0] count_nxt;
	reg count_down_nxt;
	reg overflow_event;
	assign terminal = (modulo_r == `TCIRQ_MODULO_RESET) ? `TCIRQ_COUNT_MAX : modulo_r;
	assign at_terminal = (count_r == terminal);

	always @* begin
		count_nxt = count_r;
		count_down_nxt = count_down_r;
		overflow_event = 1'b0;
		if (cnt_wr) begin
			count_nxt = `TCIRQ_COUNT_RESET;
			count_down_nxt = 1'b0;
		end else if (presc_tick) begin
			if (!center_align_select_r) begin
				if (at_terminal) begin
					count_nxt = `TCIRQ_COUNT_RESET;
					overflow_event = 1'b1;
				end else begin
					count_nxt = count_r + {{(CNT_W-1){1'b0}}, 1'b1};
				end
				count_down_nxt = 1'b0;
			end else if (!count_down_r) begin
				// center mode turns round at the terminal count and flags there
				if (at_terminal) begin
					count_nxt = count_r - {{(CNT_W-1){1'b0}}, 1'b1};
					count_down_nxt = 1'b1;
					overflow_event = 1'b1;
				end else begin
					count_nxt = count_r + {{(CNT_W-1){1'b0}}, 1'b1};
				end
			end else begin
				if (count_r == `TCIRQ_COUNT_RESET) begin
					count_nxt = count_r + {{(CNT_W-1){1'b0}}, 1'b1};
					count_down_nxt = 1'b0;
				end else begin
					count_nxt = count_r - {{(CNT_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			count_r <= `TCIRQ_COUNT_RESET;
			count_down_r <= 1'b0;
		end else begin
			count_r <= count_nxt;
			count_down_r <= count_down_nxt;
		end
	end

	// coherent byte reads: the first byte read freezes both, the opposite byte releases
	always @(posedge ref_clk) begin
		if (rst) begin
			latched_r <= 1'b0;
			first_high_r <= 1'b0;
			hold_r <= `TCIRQ_COUNT_RESET;
		end else if (sc_wr | cnt_wr) begin
			latched_r <= 1'b0;
		end else if (cnt_rd_hi | cnt_rd_lo) begin
			if (!latched_r) begin
				latched_r <= 1'b1;
				first_high_r <= cnt_rd_hi;
				hold_r <= count_r;
			end else if (first_high_r != cnt_rd_hi) begin
				latched_r <= 1'b0;
			end
		end
	end

	// overflow flag with read-then-write-zero clearing; a new event wins over the clear
	always @(posedge ref_clk) begin
		if (rst) begin
			overflow_flag_r <= 1'b0;
			overflow_armed_r <= 1'b0;
			overflow_irq_enable_r <= 1'b0;
			center_align_select_r <= 1'b0;
			clock_source_select_r <= `TCIRQ_CS_NONE;
			prescale_select_r <= 3'h0;
		end else begin
			if (overflow_event) begin
				overflow_flag_r <= 1'b1;
				overflow_armed_r <= 1'b0;
			end else if (sc_wr) begin
				if (overflow_armed_r && !wbyte[`TCIRQ_BIT_FLAG]) begin
					overflow_flag_r <= 1'b0;
				end
				overflow_armed_r <= 1'b0;
			end else if (sc_rd && overflow_flag_r) begin
				overflow_armed_r <= 1'b1;
			end
			if (sc_wr) begin
				overflow_irq_enable_r <= wbyte[`TCIRQ_BIT_IRQ_EN];
				center_align_select_r <= wbyte[`TCIRQ_BIT_CENTER];
				clock_source_select_r <= wbyte[`TCIRQ_CS_HI:`TCIRQ_CS_LO];
				prescale_select_r <= wbyte[`TCIRQ_PS_HI:`TCIRQ_PS_LO];
			end
		end
	end

	// modulo bytes; written values take effect at once
	always @(posedge ref_clk) begin
		if (rst) begin
			modulo_r <= `TCIRQ_MODULO_RESET;
		end else if (do_wr && wr_lane) begin
			if (hit(avm_address, `TCIRQ_OFS_MODULO_HIGH)) begin
				modulo_r[15:8] <= wbyte;
			end
			if (hit(avm_address, `TCIRQ_OFS_MODULO_LOW)) begin
				modulo_r[7:0] <= wbyte;
			end
		end
	end

	// channel flags follow the same clearing protocol as the overflow flag
	generate
		for (gi = 0; gi < NCH; gi = gi + 1) begin : g_chan
			wire ch_rd;
			wire ch_wr;
			assign ch_rd = do_rd & hit(avm_address, chan_ofs(gi));
			assign ch_wr = do_wr & wr_lane & hit(avm_address, chan_ofs(gi));
			always @(posedge ref_clk) begin
				if (rst) begin
					channel_event_flag_r[gi] <= 1'b0;
					channel_armed_r[gi] <= 1'b0;
					channel_irq_enable_r[gi] <= 1'b0;
				end else begin
					if (pin_rise[gi+1]) begin
						channel_event_flag_r[gi] <= 1'b1;
						channel_armed_r[gi] <= 1'b0;
					end else if (ch_wr) begin
						if (channel_armed_r[gi] && !wbyte[`TCIRQ_BIT_FLAG]) begin
							channel_event_flag_r[gi] <= 1'b0;
						end
						channel_armed_r[gi] <= 1'b0;
					end else if (ch_rd && channel_event_flag_r[gi]) begin
						channel_armed_r[gi] <= 1'b1;
					end
					if (ch_wr) begin
						channel_irq_enable_r[gi] <= wbyte[`TCIRQ_BIT_IRQ_EN];
					end
				end
			end
		end
	endgenerate

	// read mux; a frozen byte comes from the hold buffer
	reg [7:0] rbyte;
	integer k;
	always @* begin
		rbyte = 8'h00;
		if (hit(avm_address, `TCIRQ_OFS_STATUS_CONTROL)) begin
			rbyte = {overflow_flag_r, overflow_irq_enable_r, center_align_select_r,
				clock_source_select_r, prescale_select_r};
		end else if (hit(avm_address, `TCIRQ_OFS_COUNTER_HIGH)) begin
			rbyte = latched_r ? hold_r[15:8] : count_r[15:8];
		end else if (hit(avm_address, `TCIRQ_OFS_COUNTER_LOW)) begin
			rbyte = latched_r ? hold_r[7:0] : count_r[7:0];
		end else if (hit(avm_address, `TCIRQ_OFS_MODULO_HIGH)) begin
			rbyte = modulo_r[15:8];
		end else if (hit(avm_address, `TCIRQ_OFS_MODULO_LOW)) begin
			rbyte = modulo_r[7:0];
		end
		for (k = 0; k < NCH; k = k + 1) begin
			if (hit(avm_address, chan_ofs(k))) begin
				rbyte = {channel_event_flag_r[k], channel_irq_enable_r[k], 6'h00};
			end
		end
	end

	// avalon answer: waitrequest drops for one cycle after each take
	always @(posedge ref_clk) begin
		if (rst) begin
			avm_waitrequest <= 1'b1;
			avm_readdata <= 32'h00000000;
		end else begin
			avm_waitrequest <= ~take;
			if (do_rd) begin
				avm_readdata <= {24'h000000, rbyte};
			end
		end
	end

	// level interrupt, registered so it leaves straight from a flip-flop
	always @(posedge ref_clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= (overflow_flag_r & overflow_irq_enable_r) |
				(|(channel_event_flag_r & channel_irq_enable_r));
		end
	end
endmodule // tcirq_core

// *** bench/tcirq_host.sv ***
// cpu side bus master model for the register port
`timescale 1ns/1ps
module tcirq_host (
	ref_clk,
	avm_address,
	avm_read,
	avm_write,
	avm_writedata,
	avm_byteenable,
	avm_waitrequest
);
	input wire ref_clk;
	output logic [4:0] avm_address;
	output logic avm_read;
	output logic avm_write;
	output logic [31:0] avm_writedata;
	output logic [3:0] avm_byteenable;
	input wire avm_waitrequest;
	initial begin
		avm_address = 5'h00;
		avm_read = 1'b0;
		avm_write = 1'b0;
		avm_writedata = 32'h0;
		avm_byteenable = 4'hf;
	end
	// request held until waitrequest is seen low at a rising edge
	task automatic xfer(input logic [4:0] a, input logic w, input logic [31:0] d);
		avm_address <= a;
		avm_read <= ~w;
		avm_write <= w;
		avm_writedata <= d;
		do
			@(posedge ref_clk);
		while (avm_waitrequest);
		avm_read <= 1'b0;
		avm_write <= 1'b0;
		// released data shows the inverse so stale values are never mistaken
		avm_writedata <= ~d;
		@(posedge ref_clk);
	endtask
endmodule // tcirq_host

// *** bench/tcirq_core_asserts.sv ***
// concurrent checks on the timer counter core ports
`timescale 1ns/1ps
`include "tcirq_map.vh"
module tcirq_core_asserts #(
	parameter NCH = 2
) (
	ref_clk,
	rst,
	avm_address,
	avm_read,
	avm_write,
	avm_byteenable,
	avm_readdata,
	avm_waitrequest,
	irq
);
	input wire ref_clk;
	input wire rst;
	input wire [`TCIRQ_ADDR_W-1:0] avm_address;
	input wire avm_read;
	input wire avm_write;
	input wire [3:0] avm_byteenable;
	input wire [31:0] avm_readdata;
	input wire avm_waitrequest;
	input wire irq;
	wire take = (avm_read | avm_write) & avm_waitrequest;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	sequence s_clear;
		take && avm_write && avm_byteenable[0] && avm_address[4:3] != 2'b00;
	endsequence
	sequence s_rdlo;
		take && avm_read && avm_address == `TCIRQ_OFS_COUNTER_LOW;
	endsequence
	a_wait_one: assert property (take |=> !avm_waitrequest)
		else $error("no answer one cycle after request");
	a_wait_back: assert property (!avm_waitrequest |=> avm_waitrequest)
		else $error("answer held too long");
	a_wait_idle: assert property (!(avm_read | avm_write) && avm_waitrequest |=> avm_waitrequest)
		else $error("answer without request");
	a_byte_only: assert property (avm_readdata[31:8] == 24'h0)
		else $error("upper read bits set");
	// only the low counter byte address follows a clear in the bench
	a_clear_count: assert property (s_clear ##3 s_rdlo |=> avm_readdata[7:0] <= 8'h04)
		else $error("counter not cleared by byte write");
	a_unmapped_zero: assert property (take && avm_read && avm_address >= 5'h1c |=> avm_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_reset_out: assert property (@(posedge ref_clk) disable iff (1'b0) rst |=> avm_waitrequest && !irq && avm_readdata == 32'h0)
		else $error("outputs not idle after reset");
	// a flag or enable can only fall through a register write
	a_irq_hold: assert property (irq && !avm_write |=> irq)
		else $error("interrupt dropped without write");
endmodule // tcirq_core_asserts
bind tcirq_core tcirq_core_asserts #(.NCH(NCH)) u_tcirq_core_asserts (
	.ref_clk(ref_clk),
	.rst(rst),
	.avm_address(avm_address),
	.avm_read(avm_read),
	.avm_write(avm_write),
	.avm_byteenable(avm_byteenable),
	.avm_readdata(avm_readdata),
	.avm_waitrequest(avm_waitrequest),
	.irq(irq)
);

// *** bench/tcirq_core_bench.sv ***
// self-checking bench for the timer counter core
`timescale 1ns/1ps
`include "tcirq_map.vh"
module tcirq_core_bench;
	localparam [4:0] SC = `TCIRQ_OFS_STATUS_CONTROL;
	localparam [4:0] CH = `TCIRQ_OFS_COUNTER_HIGH;
	localparam [4:0] CL = `TCIRQ_OFS_COUNTER_LOW;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic fixed_clk_tick = 1'b0;
	logic ext_clk_pin = 1'b0;
	logic [1:0] channel_event_pin = 2'h0;
	wire [4:0] avm_address;
	wire avm_read;
	wire avm_write;
	wire [31:0] avm_writedata;
	wire [3:0] avm_byteenable;
	wire [31:0] avm_readdata;
	wire avm_waitrequest;
	wire irq;
	logic [15:0] exp_q[$];
	logic [15:0] e;
	logic [31:0] r;
	integer seed = 32'h66524bed;
	integer err_count = 0;
	integer tests_run = 0;
	integer cyc = 0;
	integer per[4] = '{2, 1, 2, 8};
	integer s, p, n;
	always #50 ref_clk = ~ref_clk;
	// fixed tick every second cycle, external pin period of eight cycles
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		fixed_clk_tick <= ~fixed_clk_tick;
		ext_clk_pin <= cyc[2];
	end
	tcirq_core u_tcirq_core (.ref_clk(ref_clk), .rst(rst), .avm_address(avm_address),
		.avm_read(avm_read), .avm_write(avm_write), .avm_writedata(avm_writedata),
		.avm_byteenable(avm_byteenable), .avm_readdata(avm_readdata),
		.avm_waitrequest(avm_waitrequest), .fixed_clk_tick(fixed_clk_tick),
		.ext_clk_pin(ext_clk_pin), .channel_event_pin(channel_event_pin), .irq(irq));
	tcirq_host u_tcirq_host (.ref_clk(ref_clk), .avm_address(avm_address),
		.avm_read(avm_read), .avm_write(avm_write), .avm_writedata(avm_writedata),
		.avm_byteenable(avm_byteenable), .avm_waitrequest(avm_waitrequest));
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		r = $random(seed);
		u_tcirq_host.xfer(a, 1'b1, {r[31:8], d});
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] lo, input logic [7:0] hi);
		exp_q.push_back({lo, hi});
		u_tcirq_host.xfer(a, 1'b0, 32'h0);
	endtask
	task automatic chk_data(input logic [31:0] d, input logic [15:0] x);
		tests_run++;
		if (!((d[31:8] === 24'h0) && ((d[7:0] >= x[15:8] && d[7:0] <= x[7:0]) === 1'b1))) begin
			err_count++;
			$display("BAD %0t read %h want %h..%h", $time, d, x[15:8], x[7:0]);
		end
	endtask
	task automatic chk_irq(input logic x);
		repeat (2) @(posedge ref_clk);
		tests_run++;
		if (irq !== x) begin
			err_count++;
			$display("BAD %0t irq %b", $time, irq);
		end
	endtask
	task automatic pulse(input integer k);
		channel_event_pin[k] <= 1'b1;
		repeat (3) @(posedge ref_clk);
		channel_event_pin[k] <= 1'b0;
		repeat (8) @(posedge ref_clk);
	endtask
	task automatic test_done;
		$display("compares %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// read data is judged at the edge the answer is taken, oldest note first
	always @(posedge ref_clk) begin
		if (avm_read && !avm_waitrequest) begin
			e = exp_q.pop_front();
			chk_data(avm_readdata, e);
		end
	end
	initial begin
		repeat (40000) @(posedge ref_clk);
		err_count++;
		test_done;
	end
	initial begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rd(SC, 8'h00, 8'h00);
		rd(CH, 8'h00, 8'h00);
		rd(CL, 8'h00, 8'h00);
		$display("done reset");
		for (s = 0; s < 4; s++) begin
			for (p = 0; p < 8; p++) begin
				if (s == 1 || p < 2) begin
					wr(SC, {3'h0, s[1:0], p[2:0]});
					wr(CH, 8'ha5);
					repeat ((40 << p) * per[s]) @(posedge ref_clk);
					rd(CL, s ? 8'd36 : 8'd0, s ? 8'd46 : 8'd0);
				end
			end
		end
		// a zero modulo must not act as terminal count zero, so no overflow yet
		rd(SC, 8'h19, 8'h19);
		$display("done counting");
		wr(SC, 8'h08);
		wr(CL, 8'h3c);
		rd(CL, 8'h00, 8'h04);
		repeat (300) @(posedge ref_clk);
		rd(CH, 8'h00, 8'h00);
		rd(CH, 8'h01, 8'h01);
		repeat (300) @(posedge ref_clk);
		rd(CL, 8'h30, 8'h3c);
		rd(CH, 8'h02, 8'h02);
		wr(SC, 8'h08);
		repeat (300) @(posedge ref_clk);
		rd(CH, 8'h03, 8'h03);
		$display("done coherency");
		wr(`TCIRQ_OFS_MODULO_LOW, 8'h10);
		wr(SC, 8'h48);
		wr(CL, 8'h00);
		for (n = 0; n < 6; n++) begin
			repeat ($unsigned($random(seed)) % 8) @(posedge ref_clk);
			rd(CL, 8'h00, 8'h10);
			rd(CH, 8'h00, 8'h00);
		end
		chk_irq(1'b1);
		wr(SC, 8'h40);
		chk_irq(1'b1);
		rd(SC, 8'hc0, 8'hc0);
		wr(SC, 8'h40);
		chk_irq(1'b0);
		rd(SC, 8'h40, 8'h40);
		wr(SC, 8'h08);
		repeat (40) @(posedge ref_clk);
		chk_irq(1'b0);
		rd(SC, 8'h88, 8'h88);
		// stop the clock first so no overflow can slip between read and clear
		wr(SC, 8'h20);
		rd(SC, 8'h20, 8'ha0);
		wr(SC, 8'h20);
		wr(CL, 8'h00);
		wr(SC, 8'h28);
		repeat (8) @(posedge ref_clk);
		rd(SC, 8'h28, 8'h28);
		repeat (20) @(posedge ref_clk);
		rd(SC, 8'ha8, 8'ha8);
		rd(CL, 8'h00, 8'h10);
		$display("done overflow");
		for (n = 0; n < 2; n++) begin
			wr(`TCIRQ_OFS_CHAN0 + 5'(4 * n), 8'h40);
			pulse(n);
			chk_irq(1'b1);
			rd(`TCIRQ_OFS_CHAN0 + 5'(4 * n), 8'hc0, 8'hc0);
			pulse(n);
			wr(`TCIRQ_OFS_CHAN0 + 5'(4 * n), 8'h40);
			rd(`TCIRQ_OFS_CHAN0 + 5'(4 * n), 8'hc0, 8'hc0);
			wr(`TCIRQ_OFS_CHAN0 + 5'(4 * n), 8'h00);
			chk_irq(1'b0);
			rd(`TCIRQ_OFS_CHAN0 + 5'(4 * n), 8'h00, 8'h00);
		end
		$display("done channels");
		rd(5'h1c, 8'h00, 8'h00);
		wr(5'h1c, 8'hff);
		rd(5'h1c, 8'h00, 8'h00);
		$display("done unmapped");
		test_done;
	end
endmodule // tcirq_core_bench
